// ---- design/walker_pkg.sv ----
package walker_pkg;

  // Register byte offsets
  localparam logic [7:0]  OFF_DESC64_LO  = 8'h00;
  localparam logic [7:0]  OFF_DESC64_HI  = 8'h04;
  localparam logic [7:0]  OFF_DESC32     = 8'h08;
  localparam logic [7:0]  OFF_CTRL       = 8'h0C;
  localparam logic [7:0]  OFF_STATUS     = 8'h10;
  localparam logic [7:0]  OFF_FAULTS     = 8'h14;
  localparam logic [7:0]  OFF_ENTRY_LO   = 8'h18;
  localparam logic [7:0]  OFF_ENTRY_HI   = 8'h1C;

  // Writable bits; reserved bits read as zero
  localparam logic [63:0] DESC64_WMASK   = 64'hFFFF_FFFF_FFFC_001F;
  localparam logic [31:0] DESC32_WMASK   = 32'hFFFF_01FF;
  localparam logic [63:0] DESC64_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [31:0] DESC32_RESET   = 32'h0000_0000;

  // Descriptor fields, vector bit 0 is the least significant
  localparam int          ORG64_LSB      = 18;
  localparam int          SIZE64_W       = 5;
  localparam int          ORG32_LSB      = 16;
  localparam int          MASK32_W       = 9;

  // Hash and group geometry
  localparam int          PAGE_W         = 16;
  localparam int          VIRTUAL_SEGMENT_ID_W         = 52;
  localparam int          HASH64_W       = 39;
  localparam int          HASH32_W       = 19;
  localparam int          BASE64_BITS    = 11;
  localparam int          BASE32_BITS    = 10;
  localparam int          EXTRA64_W      = 28;
  localparam int          GRP64_SHIFT    = 7;
  localparam int          GRP32_SHIFT    = 6;
  localparam logic [63:0] ENTRY64_BYTES  = 64'h0000_0000_0000_0010;
  localparam logic [63:0] ENTRY32_BYTES  = 64'h0000_0000_0000_0008;
  localparam logic [2:0]  LAST_SLOT      = 3'h7;
  localparam logic [4:0]  PROBES_MAX     = 5'h10;

  // Control and status bit positions; status read has second at bit 2, slot at bits 5:3, no fault bit
  localparam int          CTRL_MODE64    = 0;
  localparam int          STS_BUSY       = 0;
  localparam int          STS_FOUND      = 1;
  localparam int          STS_FAULT      = 2;
  localparam int          STS_SECOND     = 3;
  localparam int          STS_SLOT_LSB   = 4;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10
  } walk_state_t;

endpackage : walker_pkg

// ---- design/group_address_builder.sv ----
`timescale 1ns/1ps
`default_nettype none
module group_address_builder
  import walker_pkg::*;
(
  // Snapshot of descriptors and request
  input  wire logic                mode64_i,
  input  wire logic [63:0]         desc64_i,
  input  wire logic [31:0]         desc32_i,
  input  wire logic [VIRTUAL_SEGMENT_ID_W-1:0]   virtual_segment_id_i,
  input  wire logic [PAGE_W-1:0]   page_i,
  // Group addresses
  output logic      [63:0]         primary_group_address_o,
  output logic      [63:0]         secondary_group_address_o
);

  function automatic logic [EXTRA64_W-1:0] size_mask(input logic [SIZE64_W-1:0] code);
    size_mask = ~({EXTRA64_W{1'b1}} << code); // see RULE14
  endfunction : size_mask

  function automatic logic [63:0] group64(input logic [HASH64_W-1:0] h, input logic [63:0] d);
    logic [45:0]           org;
    logic [EXTRA64_W-1:0]  m;
    org = d[63:ORG64_LSB]; // see RULE10
    m   = size_mask(d[SIZE64_W-1:0]);
    // Origin gives the top bits, hash the index (see RULE11) (see RULE15)
    group64 = {org[45:EXTRA64_W], org[EXTRA64_W-1:0] | (h[HASH64_W-1:BASE64_BITS] & m),
               h[BASE64_BITS-1:0], {GRP64_SHIFT{1'b0}}};
  endfunction : group64

  function automatic logic [63:0] group32(input logic [HASH32_W-1:0] h, input logic [31:0] d);
    logic [15:0]           org;
    logic [MASK32_W-1:0]   m;
    org = d[31:ORG32_LSB]; // see RULE17
    m   = d[MASK32_W-1:0]; // see RULE19
    // Upper 16 address bits from origin (see RULE18)
    group32 = {32'h0000_0000, org[15:MASK32_W], org[MASK32_W-1:0] | (h[HASH32_W-1:BASE32_BITS] & m),
               h[BASE32_BITS-1:0], {GRP32_SHIFT{1'b0}}};
  endfunction : group32

  logic [HASH64_W-1:0] hash64;
  logic [HASH32_W-1:0] hash32;

  // Segment id folded with page index; secondary is complement (see RULE21)
  assign hash64 = virtual_segment_id_i[HASH64_W-1:0] ^ HASH64_W'(page_i);
  assign hash32 = virtual_segment_id_i[HASH32_W-1:0] ^ HASH32_W'(page_i);

  assign primary_group_address_o   = mode64_i ? group64(hash64, desc64_i) : group32(hash32, desc32_i); // see RULE8
  assign secondary_group_address_o = mode64_i ? group64(~hash64, desc64_i) : group32(~hash32, desc32_i); // see RULE9

endmodule : group_address_builder
`default_nettype wire

// ---- design/hashed_page_table_walker.sv ----
// How it works
// RULE1 - Translation miss starts a table walk
// RULE2 - Walk reads physical, coherency-required addresses
// RULE3 - Software walks must use real addressing
// RULE4 - Table power-of-two sized, size-aligned, fixed attributes
// RULE5 - 64-bit: eight 16-byte entries, 128-byte group
// RULE6 - 32-bit: eight 8-byte entries, 64-byte group
// RULE7 - Sixteen candidates; none found means page fault
// RULE8 - Primary hash plus descriptor forms first group
// RULE9 - No primary match: scan secondary group
// RULE10 - 64-bit descriptor: origin, reserved, size code
// RULE11 - 64-bit origin gives upper 46 address bits
// RULE12 - Software zeros unimplemented origin bits
// RULE13 - 64-bit size code at most 28
// RULE14 - Size code expands to 28-bit index mask
// RULE15 - Origin low bits clear under mask ones
// RULE16 - Keep size code at most 25 there
// RULE17 - 32-bit descriptor: origin, reserved, index mask
// RULE18 - 32-bit origin gives upper 16 address bits
// RULE19 - 32-bit mask of ones adds hash bits
// RULE20 - Descriptor writes need software synchronization
// RULE21 - Secondary hash is complement of primary
`timescale 1ns/1ps
`default_nettype none
module hashed_page_table_walker
  import walker_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                sys_rst_i,
  // Avalon-MM slave
  input  wire logic [7:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  // Translation miss request
  input  wire logic                miss_req_i,
  input  wire logic [VIRTUAL_SEGMENT_ID_W-1:0]   miss_virtual_segment_id_i,
  input  wire logic [PAGE_W-1:0]   miss_page_i,
  // Walk result
  output logic                     walk_busy_o,
  output logic                     walk_done_o,
  output logic                     walk_found_o,
  output logic                     walk_fault_o,
  output logic                     walk_secondary_o,
  output logic      [2:0]          walk_slot_o,
  output logic      [63:0]         walk_entry_addr_o,
  // Memory read port
  output logic                     mem_req_o,
  output logic      [63:0]         mem_addr_o,
  output logic                     mem_coherent_o,
  input  wire logic                mem_ack_i,
  input  wire logic                mem_match_i
);

  typedef struct packed {
    walk_state_t        st;
    logic               ack;
    logic [31:0]        rdata;
    logic [63:0]        desc64;
    logic [31:0]        desc32;
    logic               mode64;
    logic [63:0]        snap64;
    logic [31:0]        snap32;
    logic               snap_mode;
    logic [VIRTUAL_SEGMENT_ID_W-1:0]  virtual_segment_id;
    logic [PAGE_W-1:0]  page;
    logic               second;
    logic [2:0]         slot;
    logic [4:0]         probes;
    logic               req;
    logic [63:0]        addr;
    logic               busy;
    logic               done;
    logic               found;
    logic               fault;
    logic [63:0]        entry;
    logic [31:0]        faults;
  } state_t;

  localparam state_t STATE_RESET = '{
    st:        ST_IDLE,
    desc64:    DESC64_RESET,
    desc32:    DESC32_RESET,
    mode64:    1'b1,
    snap64:    DESC64_RESET,
    snap32:    DESC32_RESET,
    snap_mode: 1'b1,
    default:   '0
  };

  state_t      q;
  state_t      d;
  logic [63:0] grp_pri;
  logic [63:0] grp_sec;
  logic        acc;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] wm);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r & wm;
  endfunction : merge

  group_address_builder u_addr (
    .mode64_i                  (q.snap_mode),
    .desc64_i                  (q.snap64),
    .desc32_i                  (q.snap32),
    .virtual_segment_id_i                    (q.virtual_segment_id),
    .page_i                    (q.page),
    .primary_group_address_o   (grp_pri),
    .secondary_group_address_o (grp_sec)
  );

  assign acc = avs_read_i | avs_write_i;

  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    d.fault = 1'b0;
    d.ack  = 1'b0;
    // Bus: answer one cycle after the request is seen
    if (acc && !q.ack)
    begin
      d.ack = 1'b1;
      unique case (avs_address_i)
        OFF_DESC64_LO: d.rdata = q.desc64[31:0];
        OFF_DESC64_HI: d.rdata = q.desc64[63:32];
        OFF_DESC32:    d.rdata = q.desc32;
        OFF_CTRL:      d.rdata = 32'(q.mode64);
        OFF_STATUS:    d.rdata = 32'({q.slot, q.second, q.found, q.busy}) << STS_BUSY;
        OFF_FAULTS:    d.rdata = q.faults;
        OFF_ENTRY_LO:  d.rdata = q.entry[31:0];
        OFF_ENTRY_HI:  d.rdata = q.entry[63:32];
        default:       d.rdata = 32'h0000_0000;
      endcase
    end
    if (q.ack && avs_write_i)
    begin
      unique case (avs_address_i)
        OFF_DESC64_LO: d.desc64[31:0]  = merge(q.desc64[31:0], avs_writedata_i, avs_byteenable_i,
                                               DESC64_WMASK[31:0]);
        OFF_DESC64_HI: d.desc64[63:32] = merge(q.desc64[63:32], avs_writedata_i, avs_byteenable_i,
                                               DESC64_WMASK[63:32]);
        OFF_DESC32:    d.desc32 = merge(q.desc32, avs_writedata_i, avs_byteenable_i, DESC32_WMASK);
        OFF_CTRL:
        begin
          if (avs_byteenable_i[0])
          begin
            d.mode64 = avs_writedata_i[CTRL_MODE64];
          end
        end
        default: ;
      endcase
    end
    // Table walk
    unique case (q.st)
      ST_IDLE:
      begin
        if (miss_req_i) // see RULE1
        begin
          // Descriptors frozen for the whole walk (see RULE20)
          d.snap64    = q.desc64;
          d.snap32    = q.desc32;
          d.snap_mode = q.mode64;
          d.virtual_segment_id      = miss_virtual_segment_id_i;
          d.page      = miss_page_i;
          d.second    = 1'b0;
          d.slot      = 3'h0;
          d.probes    = 5'h00;
          d.busy      = 1'b1;
          d.st        = ST_ISSUE;
        end
      end
      ST_ISSUE:
      begin
        d.addr = grp_pri; // see RULE8
        d.req  = 1'b1;
        d.st   = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (mem_ack_i)
        begin
          d.probes = q.probes + 5'h01;
          if (mem_match_i)
          begin
            d.req   = 1'b0;
            d.busy  = 1'b0;
            d.done  = 1'b1;
            d.found = 1'b1;
            d.entry = q.addr;
            d.st    = ST_IDLE;
          end
          else if (q.slot != LAST_SLOT)
          begin
            d.slot = q.slot + 3'h1;
            // Step one entry within the group (see RULE5) (see RULE6)
            d.addr = q.addr + (q.snap_mode ? ENTRY64_BYTES : ENTRY32_BYTES);
          end
          else if (!q.second)
          begin
            d.second = 1'b1; // see RULE9
            d.slot   = 3'h0;
            d.addr   = grp_sec;
          end
          else
          begin
            // All sixteen slots missed (see RULE7)
            d.req    = 1'b0;
            d.busy   = 1'b0;
            d.done   = 1'b1;
            d.found  = 1'b0;
            d.fault  = 1'b1;
            d.faults = q.faults + 32'h0000_0001;
            d.st     = ST_IDLE;
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      q <= STATE_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign avs_readdata_o    = q.rdata;
  assign avs_waitrequest_o = ~q.ack;
  assign walk_busy_o       = q.busy;
  assign walk_done_o       = q.done;
  assign walk_found_o      = q.found;
  assign walk_fault_o      = q.fault;
  assign walk_secondary_o  = q.second;
  assign walk_slot_o       = q.slot;
  assign walk_entry_addr_o = q.entry;
  assign mem_req_o         = q.req;
  assign mem_addr_o        = q.addr;
  // Walk reads are physical and always coherency-required (see RULE2)
  assign mem_coherent_o    = q.req;

  // Checks
  sequence s_walk_start;
    (q.st == ST_IDLE) && miss_req_i;
  endsequence

  sequence s_last_primary_miss;
    mem_ack_i && !mem_match_i && (q.slot == LAST_SLOT) && !q.second;
  endsequence

  a_coherent_access: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // see RULE2
    mem_req_o |-> mem_coherent_o)
    else $error("walk read not marked coherent");

  a_walk_starts: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // see RULE1
    s_walk_start |=> walk_busy_o ##1 (mem_req_o && !walk_secondary_o && walk_slot_o == 3'h0))
    else $error("miss did not start a primary walk");

  a_primary_addr: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // see RULE8
    (q.st == ST_ISSUE) |=> (mem_addr_o == $past(grp_pri)))
    else $error("first probe not at primary group");

  a_secondary_switch: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // see RULE9
    s_last_primary_miss |=> (walk_secondary_o && walk_slot_o == 3'h0 && mem_addr_o == $past(grp_sec)))
    else $error("secondary group not entered");

  a_group_align64: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // see RULE5
    (mem_req_o && q.snap_mode && walk_slot_o == 3'h0) |-> (mem_addr_o[GRP64_SHIFT-1:0] == '0))
    else $error("64-bit group not 128-byte aligned");

  a_group_align32: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // see RULE6
    (mem_req_o && !q.snap_mode && walk_slot_o == 3'h0) |-> (mem_addr_o[GRP32_SHIFT-1:0] == '0))
    else $error("32-bit group not 64-byte aligned");

  a_entry_step: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // see RULE5
    (mem_ack_i && !mem_match_i && q.slot != LAST_SLOT && q.st == ST_WAIT)
      |=> (mem_addr_o == $past(mem_addr_o) + (q.snap_mode ? ENTRY64_BYTES : ENTRY32_BYTES)))
    else $error("entry step size wrong");

  a_fault_sixteen: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // see RULE7
    walk_fault_o |-> (q.probes == PROBES_MAX && walk_done_o && !walk_found_o && !walk_busy_o))
    else $error("fault without sixteen probes");

  a_origin_top64: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // see RULE11
    (mem_req_o && q.snap_mode) |-> (mem_addr_o[63:ORG64_LSB+EXTRA64_W] == q.snap64[63:ORG64_LSB+EXTRA64_W]))
    else $error("64-bit origin bits not on address");

  a_upper_zero32: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // see RULE18
    (mem_req_o && !q.snap_mode) |-> (mem_addr_o[63:32] == 32'h0000_0000 &&
      mem_addr_o[31:ORG32_LSB+MASK32_W] == q.snap32[31:ORG32_LSB+MASK32_W]))
    else $error("32-bit address upper bits wrong");

  a_bus_answer: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // bus answers for one cycle, then waitrequest again
    (acc && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle");

endmodule : hashed_page_table_walker
`default_nettype wire

// ---- tb/table_memory_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module table_memory_model
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // Memory read port
  input  wire logic        mem_req_i,
  input  wire logic [63:0] mem_addr_i,
  output logic             mem_ack_o,
  output logic             mem_match_o,
  // Table contents and pace
  input  wire logic [63:0] hit_addr_i,
  input  wire logic [3:0]  delay_i
);
  logic [3:0] wait_q;
  // Answers after delay_i+1 idle cycles, delay_i taken at the previous answer; match toggles when no answer
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      mem_ack_o   <= 1'b0;
      mem_match_o <= 1'b0;
      wait_q      <= 4'h0;
    end
    else if (mem_ack_o)
    begin
      mem_ack_o   <= 1'b0;
      mem_match_o <= ~mem_match_o;
      wait_q      <= delay_i;
    end
    else if (mem_req_i && wait_q == 4'h0)
    begin
      mem_ack_o   <= 1'b1;
      mem_match_o <= (mem_addr_i == hit_addr_i);
    end
    else
    begin
      mem_match_o <= ~mem_match_o;
      if (mem_req_i)
        wait_q <= wait_q - 4'h1;
    end
  end
endmodule : table_memory_model
`default_nettype wire

// ---- tb/hashed_page_table_walker_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module hashed_page_table_walker_tb_top
  import walker_pkg::*;
();
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic avs_waitrequest_o, miss_req_i = 1'b0;
  logic [VIRTUAL_SEGMENT_ID_W-1:0] miss_virtual_segment_id_i = '0;
  logic [PAGE_W-1:0] miss_page_i = '0;
  logic walk_busy_o, walk_done_o, walk_found_o, walk_fault_o, walk_secondary_o;
  logic [2:0] walk_slot_o;
  logic [63:0] walk_entry_addr_o, mem_addr_o, last_hit;
  logic mem_req_o, mem_coherent_o, mem_ack_i, mem_match_i;
  logic [63:0] hit_addr = 64'h1;
  logic [3:0] delay = 4'h0;
  int err_count = 0, samples_checked = 0, cyc = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  hashed_page_table_walker DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .miss_req_i(miss_req_i), .miss_virtual_segment_id_i(miss_virtual_segment_id_i),
    .miss_page_i(miss_page_i), .walk_busy_o(walk_busy_o), .walk_done_o(walk_done_o),
    .walk_found_o(walk_found_o), .walk_fault_o(walk_fault_o), .walk_secondary_o(walk_secondary_o),
    .walk_slot_o(walk_slot_o), .walk_entry_addr_o(walk_entry_addr_o), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .mem_coherent_o(mem_coherent_o), .mem_ack_i(mem_ack_i),
    .mem_match_i(mem_match_i));

  table_memory_model mem_model (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_match_o(mem_match_i),
    .hit_addr_i(hit_addr), .delay_i(delay));

  task results;
  begin
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask : results

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      $display("[ERR] %0t run timed out", $time);
      results();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
  begin
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    n = 0;
    do begin @(posedge clk_sys_i); n++; end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    chk(64'(n), 64'h2, "bus answer latency");
  end
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
  begin
    bus(1'b0, a, 32'h0, d);
    chk({32'h0, d}, {32'h0, exp}, "register read");
  end
  endtask : rd_chk

  function automatic logic [63:0] probe(input logic m, input logic [63:0] d64, input logic [31:0] d32,
                                        input logic [51:0] vs, input logic [15:0] pg, input int i);
    logic [38:0] h;
    logic [27:0] mk;
    logic [18:0] g;
    h  = vs[38:0] ^ {23'h0, pg};
    g  = vs[18:0] ^ {3'h0, pg};
    h  = (i >= 8) ? ~h : h;
    g  = (i >= 8) ? ~g : g;
    mk = (28'h1 << d64[4:0]) - 28'h1;
    if (m)
      return {d64[63:46], d64[45:18] | (h[38:11] & mk), h[10:0], 7'h0} + 64'(i % 8) * ENTRY64_BYTES;
    return {32'h0, d32[31:25], d32[24:16] | (g[18:10] & d32[8:0]), g[9:0], 6'h0} + 64'(i % 8) * ENTRY32_BYTES;
  endfunction : probe

  task automatic t_regs;
    logic [31:0] d;
  begin
    rd_chk(OFF_CTRL, 32'h1);
    rd_chk(OFF_DESC64_LO, 32'h0);
    rd_chk(OFF_DESC32, 32'h0);
    rd_chk(OFF_FAULTS, 32'h0);
    bus(1'b1, OFF_DESC64_LO, 32'hFFFF_FFFF, d);
    bus(1'b1, OFF_DESC64_HI, 32'hFFFF_FFFF, d);
    bus(1'b1, OFF_DESC32, 32'hFFFF_FFFF, d);
    bus(1'b1, OFF_FAULTS, 32'hFFFF_FFFF, d);
    bus(1'b1, 8'h40, 32'h1234_5678, d);
    rd_chk(OFF_DESC64_LO, DESC64_WMASK[31:0]);
    rd_chk(OFF_DESC64_HI, DESC64_WMASK[63:32]);
    rd_chk(OFF_DESC32, DESC32_WMASK);
    rd_chk(OFF_FAULTS, 32'h0);
    rd_chk(8'h40, 32'h0);
  end
  endtask : t_regs

  // Software keeps aligned origins and legal sizes here
  task automatic t_walk(input logic m, input logic [63:0] d64, input logic [31:0] d32, input logic [51:0] vs,
                        input logic [15:0] pg, input int hit, input logic [3:0] dly);
    logic [31:0] d;
    int n;
  begin
    bus(1'b1, OFF_CTRL, {31'h0, m}, d);
    bus(1'b1, OFF_DESC64_LO, d64[31:0], d);
    bus(1'b1, OFF_DESC64_HI, d64[63:32], d);
    bus(1'b1, OFF_DESC32, d32, d);
    @(posedge clk_sys_i);
    hit_addr    <= (hit < 16) ? probe(m, d64, d32, vs, pg, hit) : 64'h1;
    delay       <= dly;
    miss_req_i  <= 1'b1;
    miss_virtual_segment_id_i <= vs;
    miss_page_i <= pg;
    for (int i = 0; i < 16 && i <= hit; i++)
    begin
      n = 0;
      do begin @(posedge clk_sys_i); n++; miss_virtual_segment_id_i <= ~vs; end
      while (!(mem_req_o === 1'b1 && mem_ack_i === 1'b1) && n < 200);
      miss_req_i <= 1'b0;
      chk(mem_addr_o, probe(m, d64, d32, vs, pg, i), "probe address");
      chk({63'h0, mem_coherent_o}, 64'h1, "coherent");
      chk({63'h0, walk_busy_o}, 64'h1, "busy during walk");
    end
    n = 0;
    do begin @(posedge clk_sys_i); n++; end while (walk_done_o !== 1'b1 && n < 50);
    chk({63'h0, walk_found_o}, {63'h0, hit < 16}, "found");
    chk({63'h0, walk_fault_o}, {63'h0, hit >= 16}, "fault");
    chk({63'h0, walk_busy_o}, 64'h0, "busy after walk");
    if (hit < 16)
    begin
      last_hit = probe(m, d64, d32, vs, pg, hit);
      chk({60'h0, walk_secondary_o, walk_slot_o}, 64'(hit), "slot");
      chk(walk_entry_addr_o, last_hit, "entry");
    end
  end
  endtask : t_walk

  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_walk(1'b1, 64'h0000_00AB_CDEC_0000, 32'h0, 52'hF_0123_4567_89AB, 16'hBEEF, 0, 4'h0);
    t_walk(1'b1, 64'h0000_00AB_CDE0_0003, 32'h0, 52'h1_2345_6789_ABCD, 16'h0F0F, 15, 4'h3);
    t_walk(1'b1, 64'hFFFF_C000_0000_001C, 32'h0, 52'hA_5A5A_5A5A_5A5A, 16'h1234, 16, 4'h1);
    t_walk(1'b0, 64'h0, 32'h00AB_0000, 52'h0_0000_0007_1357, 16'hC3C3, 8, 4'h2);
    t_walk(1'b0, 64'h0, 32'hFE00_01FF, 52'h0_0000_0005_AAAA, 16'h5555, 16, 4'h0);
    rd_chk(OFF_FAULTS, 32'h2);
    rd_chk(OFF_ENTRY_LO, last_hit[31:0]);
    rd_chk(OFF_STATUS, 32'h0000_003C);
    results();
  end
endmodule : hashed_page_table_walker_tb_top
`default_nettype wire
